// *** design/pss_map.vh ***
`ifndef PSS_MAP_VH
`define PSS_MAP_VH
// Shutdown low-pulse minimum width, ns
`define PSS_PULSE_MIN_NS 200
// System clock period, ns
`define PSS_CLK_PERIOD_NS 50
// Reference-valid settle count before calibration may start
`define PSS_REF_SETTLE_CYC 16
// Calibration duration in cycles (stand-in for the VCO calibration engine)
`define PSS_CAL_CYC 64
// Strap level codes for three-level inputs
`define PSS_LVL_LOW 2'h0
`define PSS_LVL_MID 2'h1
`define PSS_LVL_HIGH 2'h2
// Interface type codes
`define PSS_IF_I2C 1'b0
`define PSS_IF_SPI 1'b1
`endif

// *** design/pss_startup.v ***
`timescale 1ns/1ps
// Behaviour
// [R1] Shutdown low powers down, ignores serial interface
// [R2] Shutdown rising edge launches power-on reset sequence
// [R3] Low pulses over 200ns register as hard reset
// [R4] Reset held until supplies and shutdown good
// [R5] Interface strap sampled: high SPI, low I2C
// [R6] Two three-level page straps pick start-up image
// [R7] Data pin acts SDIO or SDA per strap
// [R8] Clock pin acts SCK or SCL per strap
// [R9] Soft reset restarts calibration and PLL start-up
// [R10] Host supplies stable reference before calibration
// [R11] Host delays shutdown release until reference stable
// [R12] Resonator PLL locks once reference becomes valid
// [R13] Reference valid before paired digital PLL validation
// [R14] Host loads settings then sets soft-reset bit
// [R15] Host never toggles shutdown while EEPROM busy
// [R16] Straps latched once at reset release only
// [R17] Shutdown input synchronised and pulse-width filtered
`include "pss_map.vh"
module pss_startup #(
   parameter PULSE_MIN_NS = `PSS_PULSE_MIN_NS,
   parameter CLK_PERIOD_NS = `PSS_CLK_PERIOD_NS,
   parameter REF_SETTLE_CYC = `PSS_REF_SETTLE_CYC,
   parameter CAL_CYC = `PSS_CAL_CYC
) (
   // Clock and reset
   input wire clk_sys,
   input wire rst,
   // Pins from the system
   input wire chip_shutdown_n,
   input wire supplies_good,
   input wire reference_oscillator_in_valid,
   input wire interface_select_strap,
   input wire [1:0] page_select_strap_lo,
   input wire [1:0] page_select_strap_hi,
   // Register-side controls
   input wire soft_reset_bit,
   input wire eeprom_write_busy,
   // Serial pins, muxed by interface type
   input wire serial_data_in,
   input wire serial_clk_in,
   input wire serial_data_drive,
   input wire serial_data_oe_n_req,
   output reg spi_sdio_in,
   output reg i2c_sda_in,
   output reg spi_sck,
   output reg i2c_scl,
   output reg serial_data_out,
   output reg serial_data_oe_n,
   // Status and control out
   output reg powered_down,
   output reg serial_enable,
   output reg por_active,
   output reg iface_spi,
   output reg [3:0] page_select,
   output reg cal_start,
   output reg cal_running,
   output reg pll_startup_done,
   output reg resonator_lock_enable,
   output reg dpll_ref_validate_enable,
   output reg shutdown_during_busy
);
   // Least count rounds up
   localparam integer PULSE_CYC_RAW = (PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam integer PULSE_CYC = (PULSE_CYC_RAW < 1) ? 1 : PULSE_CYC_RAW;
   localparam [4:0] S_OFF = 5'h01;
   localparam [4:0] S_POR = 5'h02;
   localparam [4:0] S_WREF = 5'h04;
   localparam [4:0] S_CAL = 5'h08;
   localparam [4:0] S_RUN = 5'h10;

   reg [1:0] sync_q;
   reg [1:0] sdi_q;
   reg [1:0] sck_q;
   reg [1:0] sup_q;
   reg [1:0] ref_q;
   reg [1:0] ifs_q;
   reg [3:0] pg_q;
   reg [3:0] pg2_q;
   reg [7:0] low_cnt_q;
   reg pd_q;
   reg swr_q;
   reg [4:0] st_q;
   reg [15:0] cnt_q;
   wire pin_lvl = sync_q[1];
   wire swr_rise = soft_reset_bit & ~swr_q;

   // Two flops on every asynchronous pin before use
   always @(posedge clk_sys) begin
      if (rst) begin
         sync_q <= 2'h0;
         sdi_q <= 2'h0;
         sck_q <= 2'h0;
         sup_q <= 2'h0;
         ref_q <= 2'h0;
         ifs_q <= 2'h0;
         pg_q <= 4'h0;
         pg2_q <= 4'h0;
      end else begin
         sync_q <= {sync_q[0], chip_shutdown_n};
         // Serial pins are asynchronous too; two flops cost latency only
         sdi_q <= {sdi_q[0], serial_data_in};
         sck_q <= {sck_q[0], serial_clk_in};
         sup_q <= {sup_q[0], supplies_good};
         ref_q <= {ref_q[0], reference_oscillator_in_valid};
         ifs_q <= {ifs_q[0], interface_select_strap};
         pg_q <= {page_select_strap_hi, page_select_strap_lo};
         pg2_q <= pg_q;
      end
   end

   // Width filter: glitches shorter than the minimum do not reset
   always @(posedge clk_sys) begin
      if (rst) begin
         low_cnt_q <= 8'h00;
         pd_q <= 1'b1;
      end else if (pin_lvl) begin
         low_cnt_q <= 8'h00;
         pd_q <= 1'b0; // R17
      end else if (low_cnt_q >= PULSE_CYC[7:0] - 8'h01) begin
         pd_q <= 1'b1; // R3
      end else begin
         low_cnt_q <= low_cnt_q + 8'h01;
      end
   end

   always @(posedge clk_sys) begin
      if (rst) begin
         st_q <= S_OFF;
         cnt_q <= 16'h0000;
         swr_q <= 1'b0;
         iface_spi <= `PSS_IF_I2C;
         page_select <= 4'h0;
         cal_start <= 1'b0;
         shutdown_during_busy <= 1'b0;
      end else begin
         swr_q <= soft_reset_bit;
         cal_start <= 1'b0;
         if (pd_q & eeprom_write_busy)
            shutdown_during_busy <= 1'b1;
         if (pd_q) begin
            st_q <= S_OFF; // R1
            cnt_q <= 16'h0000;
         end else begin
            case (st_q)
               S_OFF: begin
                  st_q <= S_POR; // R2
               end
               S_POR: begin
                  if (sup_q[1]) begin // R4
                     iface_spi <= ifs_q[1]; // R5 R16
                     page_select <= pg2_q; // R6 R16
                     st_q <= S_WREF;
                     cnt_q <= 16'h0000;
                  end
               end
               S_WREF: begin
                  // Calibration on a bad reference would fail, so wait
                  if (!ref_q[1])
                     cnt_q <= 16'h0000;
                  else if (cnt_q >= REF_SETTLE_CYC - 1) begin
                     st_q <= S_CAL;
                     cnt_q <= 16'h0000;
                     cal_start <= 1'b1;
                  end else
                     cnt_q <= cnt_q + 16'h0001;
               end
               S_CAL: begin
                  if (swr_rise) begin
                     st_q <= S_WREF; // R9
                     cnt_q <= 16'h0000;
                  end else if (cnt_q >= CAL_CYC - 1)
                     st_q <= S_RUN;
                  else
                     cnt_q <= cnt_q + 16'h0001;
               end
               S_RUN: begin
                  if (swr_rise) begin
                     st_q <= S_WREF; // R9 R14
                     cnt_q <= 16'h0000;
                  end
               end
               default: st_q <= S_OFF;
            endcase
         end
      end
   end

   // Status and pin muxing, all registered
   always @(posedge clk_sys) begin
      if (rst) begin
         powered_down <= 1'b1;
         serial_enable <= 1'b0;
         por_active <= 1'b0;
         cal_running <= 1'b0;
         pll_startup_done <= 1'b0;
         resonator_lock_enable <= 1'b0;
         dpll_ref_validate_enable <= 1'b0;
         spi_sdio_in <= 1'b0;
         i2c_sda_in <= 1'b0;
         spi_sck <= 1'b0;
         i2c_scl <= 1'b0;
         serial_data_out <= 1'b0;
         serial_data_oe_n <= 1'b1;
      end else begin
         powered_down <= (st_q == S_OFF); // R1
         serial_enable <= (st_q == S_WREF) | (st_q == S_CAL) | (st_q == S_RUN); // R1
         por_active <= (st_q == S_POR);
         cal_running <= (st_q == S_CAL);
         pll_startup_done <= (st_q == S_RUN);
         // Resonator PLL tolerates a late reference; it just waits
         resonator_lock_enable <= (st_q != S_OFF) & (st_q != S_POR) & ref_q[1]; // R12
         dpll_ref_validate_enable <= (st_q == S_RUN) & ref_q[1]; // R13
         if (serial_enable) begin
            spi_sdio_in <= iface_spi & sdi_q[1]; // R7
            i2c_sda_in <= ~iface_spi & sdi_q[1]; // R7
            spi_sck <= iface_spi & sck_q[1]; // R8
            i2c_scl <= ~iface_spi & sck_q[1]; // R8
            // I2C data is open drain: only ever drives low
            serial_data_out <= iface_spi ? serial_data_drive : 1'b0; // R7
            serial_data_oe_n <= iface_spi ? serial_data_oe_n_req
                                          : (serial_data_oe_n_req | serial_data_drive);
         end else begin
            spi_sdio_in <= 1'b0;
            i2c_sda_in <= 1'b0;
            spi_sck <= 1'b0;
            i2c_scl <= 1'b0;
            serial_data_out <= 1'b0;
            serial_data_oe_n <= 1'b1; // R1
         end
      end
   end
endmodule

// *** tb/pss_startup_properties.sv ***
`timescale 1ns/1ps
module pss_checker (
   // Clock and reset
   input wire clk_sys,
   input wire rst,
   // Inputs watched
   input wire chip_shutdown_n,
   input wire soft_reset_bit,
   input wire serial_clk_in,
   // Outputs watched
   input wire spi_sck,
   input wire i2c_scl,
   input wire powered_down,
   input wire serial_enable,
   input wire por_active,
   input wire iface_spi,
   input wire [3:0] page_select,
   input wire cal_start,
   input wire cal_running,
   input wire pll_startup_done
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   sequence s_long_low; !chip_shutdown_n [*8]; endsequence
   sequence s_cal_go; ##1 cal_running && !cal_start; endsequence
   property p_off; powered_down |-> !serial_enable && !cal_running; endproperty
   a_off: assert property (p_off) else $error("active while down");
   property p_down; s_long_low |=> powered_down; endproperty
   a_down: assert property (p_down) else $error("long low ignored");
   property p_filt; $rose(powered_down) && !$past(rst) |-> !$past(chip_shutdown_n, 3); endproperty
   a_filt: assert property (p_filt) else $error("short low taken");
   property p_clk;
      serial_enable && $past(serial_enable) |->
         spi_sck == (iface_spi && $past(serial_clk_in, 3)) &&
         i2c_scl == (!iface_spi && $past(serial_clk_in, 3));
   endproperty
   a_clk: assert property (p_clk) else $error("clock routing");
   property p_strap; !por_active |-> $stable(page_select) && $stable(iface_spi); endproperty
   a_strap: assert property (p_strap) else $error("straps moved");
   property p_cal; cal_start |-> s_cal_go; endproperty
   a_cal: assert property (p_cal) else $error("calibration start");
   property p_soft; $rose(soft_reset_bit) && (cal_running || pll_startup_done) |-> ##[1:40] cal_start; endproperty
   a_soft: assert property (p_soft) else $error("no restart");
   property p_por; por_active |-> !serial_enable && !cal_running; endproperty
   a_por: assert property (p_por) else $error("left reset early");
endmodule
bind pss_startup pss_checker chk_u (.*);

// *** tb/pss_host_model.sv ***
`timescale 1ns/1ps
module pss_host_model (
   // Clock and fault control
   input wire clk_sys,
   input wire osc_kill,
   // Reference status to device
   output reg reference_oscillator_in_valid
);
   reg [2:0] warm_q = 3'h0;
   initial reference_oscillator_in_valid = 1'b0;
   // Slow oscillator: valid only after warm-up
   always @(posedge clk_sys) begin
      warm_q <= osc_kill ? 3'h0 : warm_q + {2'h0, warm_q != 3'h7};
      reference_oscillator_in_valid <= !osc_kill && warm_q == 3'h7;
   end
endmodule

// *** tb/pss_startup_tb.sv ***
`timescale 1ns/1ps
module pss_startup_tb;
   reg clk_sys = 1'b0, rst = 1'b1, chip_shutdown_n = 1'b0, supplies_good = 1'b1;
   reg interface_select_strap = 1'b0, soft_reset_bit = 1'b0, eeprom_write_busy = 1'b0;
   reg serial_data_in = 1'b1, serial_clk_in = 1'b1, osc_kill = 1'b0;
   reg [1:0] page_select_strap_lo = 2'h0, page_select_strap_hi = 2'h0;
   // Serial engine idle
   wire serial_data_drive = 1'b1, serial_data_oe_n_req = 1'b1;
   wire reference_oscillator_in_valid, spi_sdio_in, i2c_sda_in, spi_sck, i2c_scl;
   wire serial_data_out, serial_data_oe_n, powered_down, serial_enable, por_active;
   wire iface_spi, cal_start, cal_running, pll_startup_done, resonator_lock_enable;
   wire dpll_ref_validate_enable, shutdown_during_busy;
   wire [3:0] page_select;
   integer failures = 0, n_compared = 0, i, k;
   always #25 clk_sys = ~clk_sys;
   pss_startup #(.REF_SETTLE_CYC(2), .CAL_CYC(8)) dut_u (.*);
   pss_host_model host_u (.clk_sys(clk_sys), .osc_kill(osc_kill),
      .reference_oscillator_in_valid(reference_oscillator_in_valid));
   task check(input bit ok, input string m);
      n_compared = n_compared + 1;
      if (!ok) begin
         failures = failures + 1;
         $display("[ERR] %0t %s", $time, m);
      end
   endtask
   task give_verdict;
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task wait_done;
      for (i = 0; i < 300 && pll_startup_done !== 1'b1; i = i + 1) @(posedge clk_sys);
      check(i < 300, "no startup");
      if (i == 300) give_verdict;
   endtask
   task t_down;
      @(posedge clk_sys);
      chip_shutdown_n <= 1'b0;
      repeat (10) @(posedge clk_sys);
      check(powered_down === 1'b1 && {serial_enable, spi_sck, i2c_scl} === 3'h0, "up");
      $display("shutdown test done");
   endtask
   task t_boot(input bit spi, input [1:0] lo, input [1:0] hi);
      @(posedge clk_sys);
      interface_select_strap <= spi;
      page_select_strap_lo <= lo;
      page_select_strap_hi <= hi;
      chip_shutdown_n <= 1'b1;
      wait_done;
      check(iface_spi === spi && page_select === {hi, lo}, "strap");
      check({spi_sck, i2c_scl, spi_sdio_in, i2c_sda_in} === {spi, !spi, spi, !spi}, "route");
      $display("boot test done");
   endtask
   task t_glitch;
      @(posedge clk_sys);
      chip_shutdown_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      chip_shutdown_n <= 1'b1;
      repeat (12) @(posedge clk_sys);
      check(powered_down === 1'b0 && pll_startup_done === 1'b1, "glitch taken");
      $display("glitch test done");
   endtask
   task t_soft;
      @(posedge clk_sys);
      interface_select_strap <= 1'b1;
      page_select_strap_lo <= 2'h1;
      page_select_strap_hi <= 2'h1;
      soft_reset_bit <= 1'b1;
      for (i = 0; i < 40 && cal_start !== 1'b1; i = i + 1) @(posedge clk_sys);
      check(i < 40, "no recalibration");
      if (i == 40) give_verdict;
      soft_reset_bit <= 1'b0;
      wait_done;
      check(page_select === 4'h2 && iface_spi === 1'b0, "resampled");
      $display("soft reset test done");
   endtask
   task t_bringup;
      t_down;
      supplies_good <= 1'b0;
      osc_kill <= 1'b1;
      chip_shutdown_n <= 1'b1;
      repeat (20) @(posedge clk_sys);
      check(por_active === 1'b1 && serial_enable === 1'b0, "early release");
      supplies_good <= 1'b1;
      repeat (30) @(posedge clk_sys);
      check(serial_enable === 1'b1 && cal_running === 1'b0, "cal without ref");
      osc_kill <= 1'b0;
      wait_done;
      check(resonator_lock_enable === 1'b1 && page_select === 4'h5, "no lock");
      $display("bring-up test done");
   endtask
   task t_busy;
      @(posedge clk_sys);
      eeprom_write_busy <= 1'b1;
      t_down;
      check(shutdown_during_busy === 1'b1, "busy shutdown unflagged");
      eeprom_write_busy <= 1'b0;
      rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      check(shutdown_during_busy === 1'b0 && powered_down === 1'b1, "reset state");
      $display("busy test done");
   endtask
   initial begin
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      for (k = 0; k < 3; k = k + 1) begin
         t_down;
         t_boot(k[0], k[1:0], 2'h2 - k[1:0]);
      end
      t_glitch;
      t_soft;
      t_bringup;
      t_busy;
      give_verdict;
   end
endmodule
